// file: card_io_host.sv
module card_io_host #(
  parameter int unsigned reset_pulse_cycles =
    card_io_host_pkg::reset_pulse_cycles,
  parameter int unsigned reset_setup_cycles =
    card_io_host_pkg::reset_setup_cycles
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // User request
  input wire logic req_valid_i,
  input wire logic req_word_i,
  input wire logic req_odd_i,
  output logic req_ready_o,
  output logic [15:0] rsp_data_o,
  output logic rsp_valid_o,
  output logic rsp_word_o,
  // Card pins
  output card_io_host_pkg::pins_type pins_o,
  input wire logic port_width_word_n_i,
  input wire logic wait_n_i,
  input wire logic [15:0] data_i
);
  typedef enum {
    st_reset,
    st_settle,
    st_idle,
    st_setup,
    st_strobe,
    st_hold
  } state_type;

  localparam logic [23:0] setup_count =
    24'(card_io_host_pkg::setup_cycles);
  localparam logic [23:0] sample_count =
    24'(card_io_host_pkg::sample_cycles);

  state_type state;
  logic [23:0] count;
  logic [1:0] wait_sync;
  logic [1:0] width_sync;
  logic [15:0] data_meta;
  logic [15:0] data_sync;
  logic word_req;
  logic odd_phase;
  logic split;
  logic [7:0] even_byte;
  card_io_host_pkg::pins_type pins;

  wire wait_active = ~wait_sync[1];
  wire word_port = ~width_sync[1];
  wire count_done = (count == 24'd0);
  wire [23:0] count_dec = count - 24'd1;
  wire take_req = (state == st_idle) && req_valid_i;
  wire split_leg = split && !rsp_valid_o;

  always_ff @(posedge sys_clk_i) begin
    wait_sync <= {wait_sync[0], wait_n_i};
    width_sync <= {width_sync[0], port_width_word_n_i};
    data_meta <= data_i;
    data_sync <= data_meta;
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state <= st_reset;
      count <= 24'(reset_pulse_cycles);
      pins <= '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
      word_req <= 1'b0;
      odd_phase <= 1'b0;
      split <= 1'b0;
      even_byte <= 8'h00;
      req_ready_o <= 1'b0;
      rsp_valid_o <= 1'b0;
      rsp_word_o <= 1'b0;
      rsp_data_o <= 16'h0000;
    end else begin
      rsp_valid_o <= 1'b0;
      unique case (state)
        st_reset: begin
          if (count_done) begin
            pins.card_reset <= 1'b0;
            count <= 24'(reset_setup_cycles);
            state <= st_settle;
          end else begin
            count <= count_dec;
          end
        end
        st_settle: begin
          if (count_done) begin
            req_ready_o <= 1'b1;
            state <= st_idle;
          end else begin
            count <= count_dec;
          end
        end
        st_idle: begin
          if (take_req) begin
            req_ready_o <= 1'b0;
            word_req <= req_word_i;
            odd_phase <= req_odd_i;
            split <= 1'b0;
            pins.attr_select_n <= 1'b0;
            pins.byte_select_bit <= req_word_i ? 1'b0 : req_odd_i;
            pins.low_lane_enable_n <= 1'b0;
            pins.high_lane_enable_n <= ~req_word_i;
            count <= setup_count;
            state <= st_setup;
          end
        end
        st_setup: begin
          if (count_done) begin
            pins.io_read_strobe_n <= 1'b0;
            count <= sample_count;
            state <= st_strobe;
          end else begin
            count <= count_dec;
          end
        end
        st_strobe: begin
          if (!count_done) begin
            count <= count_dec;
          end else if (!wait_active) begin
            pins.io_read_strobe_n <= 1'b1;
            state <= st_hold;
            if (word_req && !split && !word_port) begin
              split <= 1'b1;
              odd_phase <= 1'b0;
            end else if (split && !odd_phase) begin
              even_byte <= data_sync[7:0];
              odd_phase <= 1'b1;
            end else if (split) begin
              rsp_data_o <= {data_sync[7:0], even_byte};
              rsp_word_o <= 1'b1;
              rsp_valid_o <= 1'b1;
            end else if (word_req) begin
              rsp_data_o <= data_sync;
              rsp_word_o <= 1'b1;
              rsp_valid_o <= 1'b1;
            end else begin
              rsp_data_o <= {8'h00, data_sync[7:0]};
              rsp_word_o <= 1'b0;
              rsp_valid_o <= 1'b1;
            end
          end
        end
        st_hold: begin
          if (split_leg) begin
            pins.byte_select_bit <= odd_phase;
            pins.high_lane_enable_n <= 1'b1;
            count <= setup_count;
            state <= st_setup;
          end else begin
            pins.low_lane_enable_n <= 1'b1;
            pins.high_lane_enable_n <= 1'b1;
            pins.attr_select_n <= 1'b1;
            req_ready_o <= 1'b1;
            state <= st_idle;
          end
        end
      endcase
    end
  end

  assign pins_o = pins;
endmodule : card_io_host

// file: card_io_host_asserts.sv
module card_io_host_asserts #(
  parameter int unsigned reset_pulse_cycles = 4,
  parameter int unsigned reset_setup_cycles = 20
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic req_ready_o,
  input wire card_io_host_pkg::pins_type pins_o,
  input wire logic wait_n_i
);
  int unsigned gap;
  wire rd = !pins_o.io_read_strobe_n;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_held;
    (!wait_n_i && rd) [*3];
  endsequence
  always_ff @(posedge sys_clk_i)
    if (pins_o.card_reset) gap <= 0;
    else if (gap < reset_setup_cycles) gap <= gap + 1;
  AST_FORM: assert property (rd |-> !pins_o.attr_select_n)
    else $error("read without io select");
  AST_WAIT: assert property (s_held |=> rd)
    else $error("strobe ended under wait");
  AST_WEND: assert property ($rose(wait_n_i) |-> ##[1:6] !rd)
    else $error("strobe stuck");
  AST_RSTW: assert property ($fell(pins_o.card_reset) |->
    $past(pins_o.card_reset, reset_pulse_cycles)) else $error("short reset");
  AST_GAP: assert property (gap < reset_setup_cycles |->
    !req_ready_o && !rd) else $error("access too soon");
endmodule : card_io_host_asserts
bind card_io_host card_io_host_asserts #(
  .reset_pulse_cycles(reset_pulse_cycles),
  .reset_setup_cycles(reset_setup_cycles)
) chk (.sys_clk_i, .rst_i, .req_ready_o, .pins_o, .wait_n_i);

// file: card_io_host_pkg.sv
// How it works
// - Every input transfer is either one byte or one two-byte word.
// - If a word input sees no word-port flag, the host splits it into an even and an odd byte read.
// - The card may hold wait asserted from the cycle start and the host keeps the strobe active meanwhile.
// - The host holds card reset at least 10 us and then waits at least 20 ms before any access.
package card_io_host_pkg;
  localparam int unsigned clk_hz = 10_000_000;
  localparam int unsigned reset_pulse_width_ns = 10_000;
  localparam int unsigned reset_setup_ms = 20;
  localparam int unsigned reset_pulse_cycles =
    (reset_pulse_width_ns * (clk_hz / 1_000_000) + 999) / 1000;
  localparam int unsigned reset_setup_cycles =
    reset_setup_ms * (clk_hz / 1000);
  localparam int unsigned setup_cycles = 2;
  localparam int unsigned sample_cycles = 2;
  localparam int unsigned count_width = 24;

  typedef struct packed {
    logic low_lane_enable_n;
    logic high_lane_enable_n;
    logic attr_select_n;
    logic byte_select_bit;
    logic io_read_strobe_n;
    logic io_write_strobe_n;
    logic card_reset;
  } pins_type;

  typedef enum logic {
    size_byte,
    size_word
  } size_type;
endpackage : card_io_host_pkg

// file: card_model.sv
module card_model (
  input wire card_io_host_pkg::pins_type pins_i,
  input wire logic wide_i,
  input wire logic slow_i,
  output logic port_width_word_n_o,
  output logic wait_n_o,
  output logic [15:0] data_o
);
  timeunit 1ns;
  timeprecision 1ns;
  wire rd = !pins_i.io_read_strobe_n && !pins_i.attr_select_n;
  wire lo = rd && !pins_i.low_lane_enable_n;
  wire hi = rd && !pins_i.high_lane_enable_n;
  wire [7:0] lb = pins_i.byte_select_bit && !hi ? 8'h5c : 8'ha6;
  assign port_width_word_n_o = !(wide_i && lo && hi);
  assign wait_n_o = !(slow_i && rd);
  assign data_o = {hi ? 8'h5c : 8'ha3, lo ? lb : ~lb};
endmodule : card_model

// file: tb_card_io_input_port.sv
module tb_card_io_input_port;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'h0, rst = 1'h1, vld = 1'h0, wrd = 1'h0, odd = 1'h0;
  logic wide = 1'h0, slow = 1'h0, rdy, rsp_v, rsp_w, pw_n, wt_n;
  logic [15:0] rsp_d, dat, d;
  card_io_host_pkg::pins_type pins;
  int failures = 0, samples_checked = 0, strobes = 0;
  card_io_host #(.reset_pulse_cycles(4), .reset_setup_cycles(20)) uut (
    .sys_clk_i(clk), .rst_i(rst), .req_valid_i(vld), .req_word_i(wrd),
    .req_odd_i(odd), .req_ready_o(rdy), .rsp_data_o(rsp_d),
    .rsp_valid_o(rsp_v), .rsp_word_o(rsp_w), .pins_o(pins),
    .port_width_word_n_i(pw_n), .wait_n_i(wt_n), .data_i(dat));
  card_model card (.pins_i(pins), .wide_i(wide), .slow_i(slow),
    .port_width_word_n_o(pw_n), .wait_n_o(wt_n), .data_o(dat));
  always #50 clk = ~clk;
  always @(negedge pins.io_read_strobe_n)
    if (pins.high_lane_enable_n) strobes++;
  task automatic chk(input logic [15:0] e, g);
    samples_checked++;
    if (e !== g) begin
      failures++;
      $display("unexpected at %0t: %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic rd(input logic w, o);
    int n = 0;
    strobes = 0;
    @(posedge clk);
    #10 {vld, wrd, odd} = {1'h1, w, o};
    while (rdy !== 1'h1) #100;
    @(posedge clk);
    #10 vld = 1'h0;
    while (rsp_v !== 1'h1 && n++ < 999) #100;
    d = rsp_d;
    chk(16'h0001, 16'(rsp_v));
    chk(16'(w), 16'(rsp_w & rsp_v));
  endtask : rd
  task automatic t_bytes;
    rd(1'h0, 1'h0);
    chk(16'h00a6, d);
    rd(1'h0, 1'h1);
    chk(16'h005c, d);
  endtask : t_bytes
  task automatic t_words;
    for (int i = 0; i < 2; i++) begin
      wide = i[0];
      rd(1'h1, 1'h0);
      chk(16'h5ca6, d);
      chk(16'(2 - 2 * i), 16'(strobes));
    end
  endtask : t_words
  task automatic t_wait;
    time t0;
    t0 = $time;
    slow = 1'h1;
    fork
      rd(1'h0, 1'h1);
      #2000 slow = 1'h0;
    join
    chk(16'h005c, d);
    chk(16'h0001, 16'($time - t0 > 2000));
  endtask : t_wait
  task end_of_test;
    $display("failures %0d samples %0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (3) @(posedge clk);
    #10 rst = 1'h0;
    t_bytes();
    t_words();
    t_wait();
    end_of_test();
  end
  initial begin
    #100000;
    failures++;
    end_of_test();
  end
endmodule : tb_card_io_input_port
